/* src/sfc_pkg.sv */
// constants, opcodes and types shared by the serial flash command core
package sfc_pkg;

  // system clock period and self-timed operation time
  localparam int SFC_CLK_NS = 8;
  localparam int SFC_T_OP_NS = 2000;
  localparam int SFC_OP_CYCLES = (SFC_T_OP_NS + SFC_CLK_NS - 1) / SFC_CLK_NS;

  // reset values and status layout
  localparam logic [23:0] SFC_STATUS_RST = 24'h000000;
  localparam logic [23:0] SFC_STATUS_KEEP = 24'h0C8703;
  localparam logic [7:0] SFC_EXT_RST = 8'h00;
  localparam int SFC_BUSY_BIT = 0;
  localparam int SFC_WEL_BIT = 1;
  localparam logic [5:0] SFC_ALEN3 = 6'h18;
  localparam logic [5:0] SFC_ALEN4 = 6'h20;

  // opcodes
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_LATCH_CLR = 8'h04;
  localparam logic [7:0] OP_SR_RD0 = 8'h05;
  localparam logic [7:0] OP_SR_RD1 = 8'h35;
  localparam logic [7:0] OP_SR_RD2 = 8'h15;
  localparam logic [7:0] OP_SR_WR0 = 8'h01;
  localparam logic [7:0] OP_SR_WR1 = 8'h31;
  localparam logic [7:0] OP_SR_WR2 = 8'h11;
  localparam logic [7:0] OP_EXT_RD = 8'hC8;
  localparam logic [7:0] OP_EXT_WR = 8'hC5;
  localparam logic [7:0] OP_VOL_WE = 8'h50;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_READ4 = 8'h13;
  localparam logic [7:0] OP_FAST = 8'h0B;
  localparam logic [7:0] OP_FAST4 = 8'h0C;
  localparam logic [7:0] OP_DOUT = 8'h3B;
  localparam logic [7:0] OP_DOUT4 = 8'h3C;
  localparam logic [7:0] OP_DIO = 8'hBB;
  localparam logic [7:0] OP_DIO4 = 8'hBC;
  localparam logic [7:0] OP_QIO = 8'hEB;
  localparam logic [7:0] OP_QIO4 = 8'hEC;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_PROG4 = 8'h12;
  localparam logic [7:0] OP_QPROG = 8'h32;
  localparam logic [7:0] OP_QPROG4 = 8'h34;
  localparam logic [7:0] OP_SECT = 8'h20;
  localparam logic [7:0] OP_SECT4 = 8'h21;
  localparam logic [7:0] OP_BLK32 = 8'h52;
  localparam logic [7:0] OP_BLK32_4 = 8'h5C;
  localparam logic [7:0] OP_BLK64 = 8'hD8;
  localparam logic [7:0] OP_BLK64_4 = 8'hDC;
  localparam logic [7:0] OP_CHIP = 8'hC7;
  localparam logic [7:0] OP_CHIP_ALT = 8'h60;
  localparam logic [7:0] OP_SEC_ER = 8'h44;
  localparam logic [7:0] OP_SEC_PG = 8'h42;
  localparam logic [7:0] OP_SEC_RD = 8'h48;

  // frame states, gray along command, address, dummy, output
  typedef enum logic [2:0] {
    ST_CMD = 3'h0,
    ST_ADDR = 3'h1,
    ST_DUMMY = 3'h3,
    ST_OUT = 3'h2,
    ST_IN = 3'h6,
    ST_SKIP = 3'h7
  } sfc_state_t;

  // command classes
  typedef enum logic [3:0] {
    K_NONE, K_SET, K_CLR, K_VOL, K_SRD, K_SWR, K_XRD, K_XWR,
    K_READ, K_SECRD, K_MOD, K_SECMOD, K_CHIP
  } sfc_kind_t;

  // decoded command
  typedef struct packed {
    sfc_kind_t kind;
    logic a32;
    logic [2:0] in_w;
    logic [2:0] out_w;
    logic [5:0] dlen;
    logic [1:0] idx;
  } sfc_dec_t;

endpackage

/* src/sfc_link_sync.sv */
// two-stage synchroniser with edge detection for the link pins
module sfc_link_sync #(
  parameter int W = 6
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_pins,
  output logic [W-1:0] o_level,
  output logic [W-1:0] o_rise,
  output logic [W-1:0] o_fall
);
  logic [W-1:0] meta_q; // first stage, read only by the second
  logic [W-1:0] sync_q; // settled level
  logic [W-1:0] prev_q; // level one cycle back, for edges

  // pins idle high after reset so no false edge appears at release
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta_q <= '1;
      sync_q <= '1;
      prev_q <= '1;
    end
    else
    begin
      meta_q <= i_pins;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign o_level = sync_q;
  assign o_rise = sync_q & ~prev_q;
  assign o_fall = ~sync_q & prev_q;
endmodule

/* src/sfc_busy_timer.sv */
// self-timed cycle counter for program, erase and status write
module sfc_busy_timer #(
  parameter int CYCLES = 250
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_start,
  output logic o_busy,
  output logic o_done
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_q; // cycles left in the running operation
  logic busy_q; // operation in progress
  logic done_q; // one-cycle completion pulse

  // a start while busy is ignored; the caller refuses such commands anyway
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (!busy_q && i_start)
      begin
        busy_q <= 1'b1;
        cnt_q <= CW'(CYCLES - 1);
      end
      else if (busy_q)
      begin
        if (cnt_q == '0)
        begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
        else
          cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  assign o_busy = busy_q;
  assign o_done = done_q;
endmodule

/* src/sfc_core.sv */
// serial flash command core: frames, latches, status, extended address, reads
module sfc_core #(
  parameter int P_OP_CYCLES = sfc_pkg::SFC_OP_CYCLES,
  parameter logic [23:0] P_STATUS_INIT = sfc_pkg::SFC_STATUS_RST
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic [3:0] i_lane_in,
  output logic [3:0] o_lane_out,
  output logic [3:0] o_lane_oe,
  input wire logic i_four_byte_mode,
  input wire logic i_reset_event,
  output logic [31:0] o_mem_addr,
  output logic o_mem_sec,
  input wire logic [7:0] i_mem_data,
  output logic [23:0] o_status,
  output logic o_write_enable_latch,
  output logic o_busy_flag,
  output logic [7:0] o_ext_addr
);

  // decode an opcode into its class and phase shape
  function automatic sfc_pkg::sfc_dec_t decode(input logic [7:0] op);
    sfc_pkg::sfc_dec_t d;
    d = '{kind: sfc_pkg::K_NONE, a32: 1'b0, in_w: 3'h1, out_w: 3'h1, dlen: 6'h00, idx: 2'h0};
    unique case (op)
      sfc_pkg::OP_LATCH_SET: d.kind = sfc_pkg::K_SET;
      sfc_pkg::OP_LATCH_CLR: d.kind = sfc_pkg::K_CLR;
      sfc_pkg::OP_VOL_WE: d.kind = sfc_pkg::K_VOL;
      sfc_pkg::OP_SR_RD0: d.kind = sfc_pkg::K_SRD;
      sfc_pkg::OP_SR_RD1: d = '{sfc_pkg::K_SRD, 1'b0, 3'h1, 3'h1, 6'h00, 2'h1};
      sfc_pkg::OP_SR_RD2: d = '{sfc_pkg::K_SRD, 1'b0, 3'h1, 3'h1, 6'h00, 2'h2};
      sfc_pkg::OP_SR_WR0: d.kind = sfc_pkg::K_SWR;
      sfc_pkg::OP_SR_WR1: d = '{sfc_pkg::K_SWR, 1'b0, 3'h1, 3'h1, 6'h00, 2'h1};
      sfc_pkg::OP_SR_WR2: d = '{sfc_pkg::K_SWR, 1'b0, 3'h1, 3'h1, 6'h00, 2'h2};
      sfc_pkg::OP_EXT_RD: d.kind = sfc_pkg::K_XRD;
      sfc_pkg::OP_EXT_WR: d.kind = sfc_pkg::K_XWR;
      sfc_pkg::OP_READ, sfc_pkg::OP_READ4: d.kind = sfc_pkg::K_READ;
      sfc_pkg::OP_FAST, sfc_pkg::OP_FAST4: d = '{sfc_pkg::K_READ, 1'b0, 3'h1, 3'h1, 6'h08, 2'h0};
      sfc_pkg::OP_DOUT, sfc_pkg::OP_DOUT4: d = '{sfc_pkg::K_READ, 1'b0, 3'h1, 3'h2, 6'h08, 2'h0};
      sfc_pkg::OP_DIO, sfc_pkg::OP_DIO4: d = '{sfc_pkg::K_READ, 1'b0, 3'h2, 3'h2, 6'h08, 2'h0};
      sfc_pkg::OP_QIO, sfc_pkg::OP_QIO4: d = '{sfc_pkg::K_READ, 1'b0, 3'h4, 3'h4, 6'h18, 2'h0};
      sfc_pkg::OP_SEC_RD: d = '{sfc_pkg::K_SECRD, 1'b0, 3'h1, 3'h1, 6'h08, 2'h0};
      sfc_pkg::OP_SEC_ER, sfc_pkg::OP_SEC_PG: d.kind = sfc_pkg::K_SECMOD;
      sfc_pkg::OP_CHIP, sfc_pkg::OP_CHIP_ALT: d.kind = sfc_pkg::K_CHIP;
      sfc_pkg::OP_PROG, sfc_pkg::OP_PROG4, sfc_pkg::OP_QPROG, sfc_pkg::OP_QPROG4,
      sfc_pkg::OP_SECT, sfc_pkg::OP_SECT4, sfc_pkg::OP_BLK32, sfc_pkg::OP_BLK32_4,
      sfc_pkg::OP_BLK64, sfc_pkg::OP_BLK64_4: d.kind = sfc_pkg::K_MOD;
      default: d.kind = sfc_pkg::K_NONE;
    endcase
    // four-byte opcode variants, or the global mode, widen the address
    d.a32 = i_four_byte_mode | (op == sfc_pkg::OP_READ4) | (op == sfc_pkg::OP_FAST4)
      | (op == sfc_pkg::OP_DOUT4) | (op == sfc_pkg::OP_DIO4) | (op == sfc_pkg::OP_QIO4)
      | (op == sfc_pkg::OP_PROG4) | (op == sfc_pkg::OP_QPROG4) | (op == sfc_pkg::OP_SECT4)
      | (op == sfc_pkg::OP_BLK32_4) | (op == sfc_pkg::OP_BLK64_4);
    return d;
  endfunction

  // shift lanes in, highest group first; lane n lands on bit n of each group
  function automatic logic [31:0] shift_in(input logic [31:0] sh, input logic [3:0] ln, input logic [2:0] w);
    logic [31:0] r;
    r = {sh[30:0], ln[0]};
    if (w == 3'h2)
      r = {sh[29:0], ln[1:0]};
    else if (w == 3'h4)
      r = {sh[27:0], ln};
    return r;
  endfunction

  // replace one status byte, keeping the protected bits
  function automatic logic [23:0] merge(input logic [23:0] st, input logic [1:0] idx, input logic [7:0] b);
    logic [23:0] nv;
    nv = st;
    nv[idx*8 +: 8] = b;
    return (st & sfc_pkg::SFC_STATUS_KEEP) | (nv & ~sfc_pkg::SFC_STATUS_KEEP);
  endfunction

  // synchronised link pins: {cs_n, sclk, lanes}
  logic [5:0] pin_lvl; // settled pin levels
  logic [5:0] pin_rise; // rising edges
  logic [5:0] pin_fall; // falling edges
  sfc_link_sync #(.W(6)) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_pins({i_cs_n, i_sclk, i_lane_in}),
    .o_level(pin_lvl),
    .o_rise(pin_rise),
    .o_fall(pin_fall)
  );

  logic cs_idle; // chip select deasserted
  logic cs_rise; // end of frame
  logic clk_rise; // sampling edge inside a frame
  logic clk_fall; // launch edge inside a frame
  assign cs_idle = pin_lvl[5];
  assign cs_rise = pin_rise[5];
  assign clk_rise = pin_rise[4] & ~cs_idle;
  assign clk_fall = pin_fall[4] & ~cs_idle;

  sfc_pkg::sfc_state_t st_q; // frame phase
  logic [5:0] cnt_q; // bits taken in the current phase
  logic [31:0] sh_q; // input shift register
  sfc_pkg::sfc_dec_t dec_q; // command of this frame
  logic arm_q; // frame complete, act at deselect
  logic wel_q; // write_enable_latch
  logic vol_pend_q; // volatile enable seen in the previous frame
  logic vol_q; // this frame is a volatile status write
  logic [23:0] status_q; // status bits other than busy and latch
  logic [23:0] pend_q; // status waiting for the timed cycle
  logic nv_pend_q; // a non-volatile status write is in flight
  logic [7:0] ext_q; // extended address register
  logic [31:0] addr_q; // array address
  logic sec_q; // address targets a security register
  logic [7:0] ob_q; // outgoing byte remainder
  logic [2:0] ocnt_q; // bits already sent of the current byte
  logic [3:0] lane_out_q; // driven lane values
  logic [3:0] lane_oe_q; // lane enables
  logic busy; // busy_flag from the timer
  logic op_done; // timed cycle completed

  logic [31:0] sh_n; // shift register after this edge
  logic [5:0] cnt_n; // count after this edge
  sfc_pkg::sfc_dec_t dec_n; // decode of the byte just completed
  logic ok_n; // command allowed to proceed
  logic op_end; // opcode byte completes now
  logic addr_end; // address phase completes now
  logic [31:0] addr_n; // address formed from the input
  logic sec_ok; // security address well formed
  logic [23:0] status_rd; // status as read by the host
  logic [7:0] next_byte; // byte to start sending
  logic start; // launch a timed cycle

  always_comb
  begin
    sh_n = shift_in(sh_q, pin_lvl[3:0], (st_q == sfc_pkg::ST_CMD) ? 3'h1 : dec_q.in_w);
    cnt_n = cnt_q + 6'(dec_q.in_w);
    dec_n = decode(sh_n[7:0]);
    op_end = clk_rise && st_q == sfc_pkg::ST_CMD && cnt_q == 6'h07;
    addr_end = clk_rise && st_q == sfc_pkg::ST_ADDR
      && cnt_n == (dec_q.a32 ? sfc_pkg::SFC_ALEN4 : sfc_pkg::SFC_ALEN3);
    addr_n = dec_q.a32 ? sh_n : {ext_q, sh_n[23:0]};
    sec_ok = addr_n[31:16] == 16'h0000 && addr_n[15:12] >= 4'h1
      && addr_n[15:12] <= 4'h3 && !addr_n[11];
    status_rd = {status_q[23:2], wel_q, busy};
    // writes need the latch (status writes the latch or the volatile enable) and an idle array; array reads only an idle array
    unique case (dec_n.kind)
      sfc_pkg::K_MOD, sfc_pkg::K_SECMOD, sfc_pkg::K_CHIP, sfc_pkg::K_XWR: ok_n = wel_q && !busy;
      sfc_pkg::K_SWR: ok_n = (wel_q || vol_pend_q) && !busy;
      sfc_pkg::K_READ, sfc_pkg::K_SECRD: ok_n = !busy;
      sfc_pkg::K_NONE: ok_n = 1'b0;
      default: ok_n = 1'b1;
    endcase
    unique case (dec_q.kind)
      sfc_pkg::K_SRD: next_byte = status_rd[dec_q.idx*8 +: 8];
      sfc_pkg::K_XRD: next_byte = ext_q;
      default: next_byte = i_mem_data;
    endcase
    start = cs_rise && arm_q && (dec_q.kind == sfc_pkg::K_MOD || dec_q.kind == sfc_pkg::K_SECMOD
      || dec_q.kind == sfc_pkg::K_CHIP || (dec_q.kind == sfc_pkg::K_SWR && !vol_q));
  end

  // frame sequencer: opcode, address, dummy, data phases on rising link edges
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_q <= sfc_pkg::ST_CMD;
      cnt_q <= 6'h00;
      sh_q <= 32'h00000000;
      dec_q <= '0;
      arm_q <= 1'b0;
    end
    else if (cs_idle)
    begin
      st_q <= sfc_pkg::ST_CMD;
      cnt_q <= 6'h00;
      arm_q <= 1'b0;
    end
    else if (clk_rise)
    begin
      unique case (st_q)
        sfc_pkg::ST_CMD:
        begin
          sh_q <= sh_n;
          cnt_q <= (cnt_q == 6'h07) ? 6'h00 : cnt_q + 6'h01;
          if (cnt_q == 6'h07)
          begin
            dec_q <= dec_n;
            if (!ok_n)
              st_q <= sfc_pkg::ST_SKIP;
            else
              unique case (dec_n.kind)
                sfc_pkg::K_SRD, sfc_pkg::K_XRD: st_q <= sfc_pkg::ST_OUT;
                sfc_pkg::K_SWR, sfc_pkg::K_XWR: st_q <= sfc_pkg::ST_IN;
                sfc_pkg::K_READ, sfc_pkg::K_SECRD, sfc_pkg::K_MOD, sfc_pkg::K_SECMOD: st_q <= sfc_pkg::ST_ADDR;
                default:
                begin
                  st_q <= sfc_pkg::ST_SKIP;
                  arm_q <= 1'b1;
                end
              endcase
          end
        end
        sfc_pkg::ST_ADDR:
        begin
          sh_q <= sh_n;
          cnt_q <= addr_end ? 6'h00 : cnt_n;
          if (addr_end)
          begin
            if (dec_q.kind == sfc_pkg::K_MOD || dec_q.kind == sfc_pkg::K_SECMOD)
            begin
              // data bodies are not taken; the address alone arms the cycle
              st_q <= sfc_pkg::ST_SKIP;
              arm_q <= dec_q.kind == sfc_pkg::K_MOD || sec_ok;
            end
            else if (dec_q.kind == sfc_pkg::K_SECRD && !sec_ok)
              st_q <= sfc_pkg::ST_SKIP;
            else if (dec_q.dlen == 6'h00)
              st_q <= sfc_pkg::ST_OUT;
            else
              st_q <= sfc_pkg::ST_DUMMY;
          end
        end
        sfc_pkg::ST_DUMMY:
        begin
          sh_q <= sh_n; // mode byte lands here and is otherwise unused
          cnt_q <= cnt_n;
          if (cnt_n == dec_q.dlen)
            st_q <= sfc_pkg::ST_OUT;
        end
        sfc_pkg::ST_IN:
        begin
          sh_q <= sh_n;
          cnt_q <= cnt_q + 6'h01;
          arm_q <= cnt_q == 6'h07;
          if (cnt_q == 6'h08)
            st_q <= sfc_pkg::ST_SKIP;
        end
        default: ;
      endcase
    end
  end

  // write_enable_latch: set by the set opcode, cleared by clear when not busy, or by completion
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      wel_q <= 1'b0;
    else
    begin
      if (op_done)
        wel_q <= 1'b0;
      if (cs_rise && arm_q && dec_q.kind == sfc_pkg::K_CLR && !busy)
        wel_q <= 1'b0;
      if (cs_rise && arm_q && dec_q.kind == sfc_pkg::K_SET)
        wel_q <= 1'b1;
    end
  end

  // volatile enable only counts for the very next command
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      vol_pend_q <= 1'b0;
      vol_q <= 1'b0;
    end
    else if (op_end)
    begin
      vol_q <= vol_pend_q && dec_n.kind == sfc_pkg::K_SWR;
      vol_pend_q <= 1'b0;
    end
    else if (cs_rise)
    begin
      vol_pend_q <= arm_q && dec_q.kind == sfc_pkg::K_VOL;
      vol_q <= 1'b0;
    end
  end

  // status bits: volatile writes land at once, others after the timed cycle
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      status_q <= P_STATUS_INIT;
      pend_q <= P_STATUS_INIT;
      nv_pend_q <= 1'b0;
    end
    else if (cs_rise && arm_q && dec_q.kind == sfc_pkg::K_SWR)
    begin
      if (vol_q)
        status_q <= merge(status_q, dec_q.idx, sh_q[7:0]);
      else
      begin
        pend_q <= merge(status_q, dec_q.idx, sh_q[7:0]);
        nv_pend_q <= 1'b1;
      end
    end
    else if (op_done && nv_pend_q)
    begin
      status_q <= pend_q;
      nv_pend_q <= 1'b0;
    end
  end

  // extended address register
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      ext_q <= sfc_pkg::SFC_EXT_RST;
    else if (i_reset_event)
      ext_q <= sfc_pkg::SFC_EXT_RST;
    else if (cs_rise && arm_q && dec_q.kind == sfc_pkg::K_XWR)
      ext_q <= sh_q[7:0];
  end

  // array address: loaded after the address phase, bumped per byte sent
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      addr_q <= 32'h00000000;
      sec_q <= 1'b0;
    end
    else if (addr_end)
    begin
      addr_q <= addr_n;
      sec_q <= dec_q.kind == sfc_pkg::K_SECRD;
    end
    else if (clk_fall && st_q == sfc_pkg::ST_OUT && ocnt_q == 3'h0
      && (dec_q.kind == sfc_pkg::K_READ || dec_q.kind == sfc_pkg::K_SECRD))
      addr_q <= addr_q + 32'h00000001;
  end

  // output lanes change on falling link edges, most significant first
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ob_q <= 8'h00;
      ocnt_q <= 3'h0;
      lane_out_q <= 4'h0;
      lane_oe_q <= 4'h0;
    end
    else if (cs_idle || st_q != sfc_pkg::ST_OUT)
    begin
      ocnt_q <= 3'h0;
      lane_oe_q <= 4'h0;
    end
    else if (clk_fall)
    begin
      logic [7:0] word;
      word = (ocnt_q == 3'h0) ? next_byte : ob_q;
      ob_q <= word << dec_q.out_w;
      ocnt_q <= ocnt_q + dec_q.out_w;
      if (dec_q.out_w == 3'h4)
      begin
        lane_out_q <= word[7:4];
        lane_oe_q <= 4'hF;
      end
      else if (dec_q.out_w == 3'h2)
      begin
        lane_out_q <= {2'h0, word[7:6]};
        lane_oe_q <= 4'h3;
      end
      else
      begin
        lane_out_q <= {2'h0, word[7], 1'b0};
        lane_oe_q <= 4'h2;
      end
    end
  end

  sfc_busy_timer #(.CYCLES(P_OP_CYCLES)) u_timer (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_start(start),
    .o_busy(busy),
    .o_done(op_done)
  );

  assign o_lane_out = lane_out_q;
  assign o_lane_oe = lane_oe_q;
  assign o_mem_addr = addr_q;
  assign o_mem_sec = sec_q;
  assign o_status = status_q;
  assign o_write_enable_latch = wel_q;
  assign o_busy_flag = busy;
  assign o_ext_addr = ext_q;
endmodule

/* testbench/sfc_chk.sv */
// port assertions for the serial flash command core
module sfc_chk #(
  parameter int P_OP_CYCLES = 250
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_reset_event,
  input wire logic [3:0] o_lane_oe,
  input wire logic [31:0] o_mem_addr,
  input wire logic [23:0] o_status,
  input wire logic o_write_enable_latch,
  input wire logic o_busy_flag,
  input wire logic [7:0] o_ext_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // length of the running timed cycle
  int busy_cnt;
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      busy_cnt <= 0;
    else
      busy_cnt <= o_busy_flag ? busy_cnt + 1 : 0;
  end
  // deselected long enough for the synchroniser to see it
  sequence s_cs_idle;
    i_cs_n [*6];
  endsequence
  // timed cycle ends with no frame in flight
  sequence s_done_quiet;
    $fell(o_busy_flag) && i_cs_n && $past(i_cs_n, 8);
  endsequence
  a_latch_at_deselect: assert property ($rose(o_write_enable_latch) |-> $past(i_cs_n, 2))
    else $error("latch set inside a frame");
  a_busy_needs_latch: assert property ($rose(o_busy_flag) |-> $past(o_write_enable_latch))
    else $error("timed cycle without latch");
  a_clear_not_busy: assert property ($fell(o_write_enable_latch) |-> ##[0:1] !o_busy_flag)
    else $error("latch dropped during timed cycle");
  a_done_clears_latch: assert property (s_done_quiet |-> ##[0:1] !o_write_enable_latch)
    else $error("latch kept after timed cycle");
  a_keep_bits_fixed: assert property ($changed(o_status) |->
    ((o_status ^ $past(o_status)) & sfc_pkg::SFC_STATUS_KEEP) == 24'h000000)
    else $error("protected status bit changed");
  a_busy_span: assert property ($fell(o_busy_flag) |->
    busy_cnt inside {[P_OP_CYCLES - 1 : P_OP_CYCLES + 1]})
    else $error("timed cycle length wrong");
  a_ext_reset_clear: assert property (i_reset_event |-> ##[1:2] o_ext_addr == 8'h00)
    else $error("extended address kept after reset");
  a_read_not_busy: assert property ($changed(o_mem_addr) |-> !o_busy_flag)
    else $error("array read during timed cycle");
  a_lanes_released: assert property (s_cs_idle |-> o_lane_oe == 4'h0)
    else $error("lanes driven while deselected");
endmodule
bind sfc_core sfc_chk #(.P_OP_CYCLES(P_OP_CYCLES)) i_sfc_chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
  .i_cs_n(i_cs_n), .i_reset_event(i_reset_event), .o_lane_oe(o_lane_oe), .o_mem_addr(o_mem_addr),
  .o_status(o_status), .o_write_enable_latch(o_write_enable_latch), .o_busy_flag(o_busy_flag),
  .o_ext_addr(o_ext_addr));

/* testbench/sfc_host.sv */
// host controller model driving the serial link, mode 3
module sfc_host (
  input wire logic i_sys_clk,
  input wire logic [3:0] i_oe,
  input wire logic [3:0] i_out,
  output logic o_sclk,
  output logic o_cs_n,
  output logic [3:0] o_lane
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] drv = 4'hF; // host side of each lane
  logic [31:0] rx; // lane one samples
  logic [63:0] rxd; // lane one and zero pairs
  logic [7:0] rxq; // all four lanes, last two clocks
  // wire level: device wins where it drives
  assign o_lane = (i_oe & i_out) | (~i_oe & drv);
  initial
  begin
    o_sclk = 1'b1;
    o_cs_n = 1'b1;
  end
  // half of the 160 ns link period
  task automatic half();
    repeat (10) @(posedge i_sys_clk);
    #1;
  endtask
  // opcode MSB first on lane zero, then nb bits, then nr output clocks
  // after the opcode, nb bits go out w lanes wide, highest lane first
  task automatic frame(input logic [7:0] op, input logic [63:0] tx = 0, input int nb = 0, input int nr = 0,
    input int w = 1);
    logic [71:0] sh;
    int k;
    sh = {op, tx << (64 - nb)};
    rx = '0;
    rxd = '0;
    half();
    o_cs_n = 1'b0;
    for (int i = 0; i < 8 + nb / w + nr; i++)
    begin
      half();
      o_sclk = 1'b0;
      // released lines toggle so a stale level never passes
      k = (i < 8) ? 1 : w;
      drv = ~drv;
      if (i < 8 + nb / w)
        for (int j = 0; j < k; j++)
          drv[k - 1 - j] = sh[71 - j];
      sh = sh << k;
      half();
      o_sclk = 1'b1;
      rx = {rx[30:0], o_lane[1]};
      rxd = {rxd[61:0], o_lane[1:0]};
      rxq = {rxq[3:0], o_lane};
    end
    half();
    o_cs_n = 1'b1; // raised half a link period after the last bit
    half();
  endtask
endmodule

/* testbench/serial_flash_command_core_test.sv */
// self-checking bench for the serial flash command core
module serial_flash_command_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk;
  logic rst;
  logic four_byte;
  logic reset_event;
  logic sclk, cs_n, write_enable_latch, busy, mem_sec;
  logic [3:0] lane, lane_out, lane_oe;
  logic [31:0] mem_addr;
  logic [23:0] status;
  logic [7:0] ext_addr;
  int failures = 0;
  int compares = 0;
  // array model: each byte is its low address scrambled
  logic [7:0] mem_data;
  assign mem_data = mem_addr[7:0] ^ 8'h5A;
  always #4 sys_clk = ~sys_clk;
  // timed cycle long enough to poll inside it
  sfc_core #(.P_OP_CYCLES(1600)) i_sfc_core (.i_sys_clk(sys_clk), .i_rst(rst), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_lane_in(lane), .o_lane_out(lane_out), .o_lane_oe(lane_oe), .i_four_byte_mode(four_byte),
    .i_reset_event(reset_event), .o_mem_addr(mem_addr), .o_mem_sec(mem_sec), .i_mem_data(mem_data),
    .o_status(status), .o_write_enable_latch(write_enable_latch), .o_busy_flag(busy), .o_ext_addr(ext_addr));
  sfc_host i_sfc_host (.i_sys_clk(sys_clk), .i_oe(lane_oe), .i_out(lane_out), .o_sclk(sclk), .o_cs_n(cs_n),
    .o_lane(lane));
  task automatic give_verdict();
    if (failures == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // bounded wait for the timed cycle to end
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0)
    begin
      @(posedge sys_clk);
      #1;
      n++;
      if (n > 4000)
      begin
        failures++;
        give_verdict();
      end
    end
    // latch and status settle one cycle after the busy flag drops
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task automatic t_reset();
    check("wel", write_enable_latch, 0);
    check("ext", ext_addr, 0);
    check("busy", busy, 0);
  endtask
  // latch, unknown opcode and refused writes
  task automatic t_latch();
    i_sfc_host.frame(8'h06);
    check("wel set", write_enable_latch, 1);
    i_sfc_host.frame(8'h99, 64'hFF, 8);
    check("wel kept", write_enable_latch, 1);
    i_sfc_host.frame(8'h01, 64'h1FF, 9);
    check("nine bits busy", busy, 0);
    check("nine bits sr", status, 0);
    i_sfc_host.frame(8'h04);
    check("wel clear", write_enable_latch, 0);
    i_sfc_host.frame(8'h31, 64'hFF, 8);
    check("no latch busy", busy, 0);
    check("no latch sr", status, 0);
  endtask
  // polling and refused commands inside a timed cycle
  task automatic t_busy();
    i_sfc_host.frame(8'h06);
    i_sfc_host.frame(8'h01, 64'hAA, 8);
    check("busy", busy, 1);
    i_sfc_host.frame(8'h04);
    i_sfc_host.frame(8'h05, 0, 0, 8);
    check("poll", i_sfc_host.rx[7:0], 8'h03);
    i_sfc_host.frame(8'h03, 64'h10, 24, 8);
    check("busy read", mem_addr, 0);
    wait_idle();
    check("wel done", write_enable_latch, 0);
    check("sr0", status[7:0], 8'hA8);
  endtask
  // all three write and read opcodes, read repeats
  task automatic t_table();
    logic [7:0] wr [3] = '{8'h01, 8'h31, 8'h11};
    logic [7:0] rd [3] = '{8'h05, 8'h35, 8'h15};
    logic [7:0] ex [3] = '{8'hFC, 8'h78, 8'hF3};
    for (int i = 0; i < 3; i++)
    begin
      i_sfc_host.frame(8'h06);
      i_sfc_host.frame(wr[i], 64'hFF, 8);
      wait_idle();
      i_sfc_host.frame(rd[i], 0, 0, 16);
      check("sr byte", i_sfc_host.rx[15:0], {ex[i], ex[i]});
    end
  endtask
  task automatic t_volatile();
    i_sfc_host.frame(8'h50);
    i_sfc_host.frame(8'h11, 64'h00, 8);
    check("vol sr", status[23:16], 8'h00);
    check("vol busy", busy, 0);
    check("vol wel", write_enable_latch, 0);
  endtask
  // extended address write, use, read back and reset
  task automatic t_ext();
    i_sfc_host.frame(8'h06);
    i_sfc_host.frame(8'hC5, 64'h03, 8);
    wait_idle();
    check("ext", ext_addr, 8'h03);
    i_sfc_host.frame(8'h03, 64'h10, 24, 16);
    check("read", i_sfc_host.rx[15:0], 16'h4A4B);
    check("upper", mem_addr[31:24], 8'h03);
    i_sfc_host.frame(8'hC8, 0, 0, 8);
    check("ext rd", i_sfc_host.rx[7:0], 8'h03);
    reset_event = 1'b1;
    @(posedge sys_clk);
    #1;
    reset_event = 1'b0;
    repeat (3) @(posedge sys_clk);
    check("ext rst", ext_addr, 0);
  endtask
  task automatic t_reads();
    i_sfc_host.frame(8'h0B, 64'hFF00, 32, 8);
    check("fast", i_sfc_host.rx[7:0], 8'hA5);
    i_sfc_host.frame(8'h3B, 64'h2000, 32, 4);
    check("dual", i_sfc_host.rxd[7:0], 8'h7A);
    i_sfc_host.frame(8'h48, 64'h00100500, 32, 8);
    check("sec", i_sfc_host.rx[7:0], 8'h5F);
    check("sec flag", mem_sec, 1);
    i_sfc_host.frame(8'hBB, 64'h3000, 32, 4, 2);
    check("dual io", i_sfc_host.rxd[7:0], 8'h6A);
    i_sfc_host.frame(8'hEB, 64'h40000000, 48, 2, 4);
    check("quad io", i_sfc_host.rxq, 8'h1A);
    four_byte = 1'b1;
    i_sfc_host.frame(8'h03, 64'h01000021, 32, 8);
    check("a32", i_sfc_host.rx[7:0], 8'h7B);
    check("a32 top", mem_addr[31:24], 8'h01);
    check("a32 sec", mem_sec, 0);
    four_byte = 1'b0;
  endtask
  initial
  begin
    sys_clk = 1'b0;
    rst = 1'b1;
    four_byte = 1'b0;
    reset_event = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    repeat (8) @(posedge sys_clk);
    #1;
    t_reset();
    t_latch();
    t_busy();
    t_table();
    t_volatile();
    t_ext();
    t_reads();
    give_verdict();
  end
endmodule
